/* rtl/serial_port_pkg.sv */
// Constants for the serial port receiver and synchronous slave block.
// Assumes a 25 MHz system clock and a 32-bit Avalon-MM register bus.
// ==========================================================================
package serial_port_pkg;

  // ========================================================================
  // Register word addresses, each register in byte lane 0
  localparam logic [3:0] RCV_CTRL_ADDR  = 4'h0;
  localparam logic [3:0] XMT_CTRL_ADDR  = 4'h1;
  localparam logic [3:0] BAUD_CTRL_ADDR = 4'h2;
  localparam logic [3:0] BAUD_LO_ADDR   = 4'h3;
  localparam logic [3:0] BAUD_HI_ADDR   = 4'h4;
  localparam logic [3:0] RCV_BUF_ADDR   = 4'h5;
  localparam logic [3:0] XMT_REG_ADDR   = 4'h6;
  localparam logic [3:0] IRQ_STAT_ADDR  = 4'h7;
  localparam logic [3:0] IRQ_MASK_ADDR  = 4'h8;
  localparam logic [3:0] SYS_CTRL_ADDR  = 4'h9;

  // ========================================================================
  // Receive status control fields
  localparam int RC_PORT_EN   = 7;
  localparam int RC_NINE      = 6;
  localparam int RC_SINGLE    = 5;
  localparam int RC_CONT      = 4;
  localparam int RC_ADDR_DET  = 3;
  localparam int RC_FRAME_ERR = 2;
  localparam int RC_OVERRUN   = 1;
  localparam int RC_NINTH     = 0;

  // Transmit status control fields
  localparam int TX_CLK_MST = 7;
  localparam int TX_NINE    = 6;
  localparam int TX_EN      = 5;
  localparam int TX_SYNC    = 4;
  localparam int TX_EMPTY   = 1;
  localparam int TX_NINTH   = 0;

  // Baud control fields
  localparam int BC_AB_OVF = 7;
  localparam int BC_IDLE   = 6;
  localparam int BC_WIDE   = 3;
  localparam int BC_WAKE   = 1;
  localparam int BC_AB_EN  = 0;

  // Interrupt status bits, also irq enables
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;

  // System control bits
  localparam int SC_SLEEP = 0;
  localparam int SC_PERI  = 1;
  localparam int SC_GLOB  = 2;

  // ========================================================================
  // Reset values
  localparam logic [7:0] RCV_CTRL_RST  = 8'h00;
  localparam logic [7:0] XMT_CTRL_RST  = 8'h02;
  localparam logic [7:0] BAUD_CTRL_RST = 8'h40;

  // Last sample count of a bit (16 samples per bit) and receive sample point
  localparam logic [3:0] OVERSAMPLE = 4'hf;
  localparam logic [3:0] MID_SAMPLE = 4'h7;

endpackage

/* rtl/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter.
// Assumes the pin is asynchronous to sys_clk_in.
`timescale 1ns/10ps
module pin_sync (
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  // Pin and filtered level
  input  wire logic pin_in,
  output logic      level_out
);

  typedef struct packed {
    logic [2:0] stage;
    logic       level;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // Shift chain; level follows once last two agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.stage = {st_r.stage[1:0], pin_in};
    if (st_r.stage[1] == st_r.stage[2]) begin
      st_nxt.level = st_r.stage[2];
    end
  end

  // State register, idle high
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st_r <= '{stage: 3'h7, level: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.level;

endmodule

/* rtl/serial_port.sv */
// Serial port: async receiver with address detect and wake,
// synchronous slave transmit and receive on an external clock.
// Assumes an Avalon-MM master and a remote transmitter or clock master.
`timescale 1ns/10ps
module serial_port #(
  parameter int AB_WIDTH = 16
) (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Serial pins
  input  wire logic        rx_pin_in,
  input  wire logic        ck_pin_in,
  output logic             dt_out,
  output logic             dt_oe_out,
  // Interrupt and wake
  output logic             irq_out,
  output logic             wake_out
);

  // Elaboration check on the auto-baud counter width
  if (AB_WIDTH < 8 || AB_WIDTH > 16) begin : g_bad_ab_width
    $error("AB_WIDTH out of range");
  end

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;

  typedef struct packed {
    logic [7:0]  rcv_ctrl;
    logic [7:0]  xmt_ctrl;
    logic [7:0]  baud_ctrl;
    logic [15:0] divisor;
    logic [7:0]  rcv_buf;
    logic [7:0]  xmt_reg;
    logic        xmt_full;
    logic        xmt_ninth;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic [2:0]  sys_ctrl;
    logic        ack;
    logic [31:0] rdata;
    logic [15:0] div_cnt;
    logic [3:0]  smp_cnt;
    logic [3:0]  bit_cnt;
    logic [8:0]  rx_shift;
    rx_state_t   rx_st;
    logic        rx_prev;
    logic        ck_prev;
    logic [8:0]  tx_shift;
    logic [3:0]  tx_left;
    logic        tx_busy;
    logic [AB_WIDTH-1:0] ab_cnt;
  } port_state_t;

  port_state_t st_r;
  port_state_t st_nxt;
  logic        rx_lvl;
  logic        ck_lvl;
  logic        acc;
  logic        wr_hit;
  logic        tick;
  logic        sync_mode;
  logic        rx_on;
  logic        ck_fall;
  logic        ck_rise;
  logic [15:0] div_top;

  // Pin synchronisers
  pin_sync rx_sync (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .pin_in     (rx_pin_in),
    .level_out  (rx_lvl)
  );
  pin_sync ck_sync (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .pin_in     (ck_pin_in),
    .level_out  (ck_lvl)
  );

  // Byte lane merge for register writes
  function automatic logic [7:0] lane0(input logic [7:0] old,
                                       input logic [31:0] wd,
                                       input logic [3:0] be);
    lane0 = be[0] ? wd[7:0] : old;
  endfunction

  // Bus handshake and decoded strobes
  assign acc       = (avs_read_in | avs_write_in) & ~st_r.ack;
  assign wr_hit    = avs_write_in & ~st_r.ack;
  assign sync_mode = st_r.xmt_ctrl[serial_port_pkg::TX_SYNC];
  assign rx_on     = st_r.rcv_ctrl[serial_port_pkg::RC_PORT_EN]
                   & (st_r.rcv_ctrl[serial_port_pkg::RC_CONT]
                   | st_r.rcv_ctrl[serial_port_pkg::RC_SINGLE]);
  assign ck_fall   = st_r.ck_prev & ~ck_lvl;
  assign ck_rise   = ~st_r.ck_prev & ck_lvl;
  // Divider width follows the wide generator select
  assign div_top   = st_r.baud_ctrl[serial_port_pkg::BC_WIDE]
                   ? st_r.divisor : {8'h00, st_r.divisor[7:0]};
  assign tick      = (st_r.div_cnt == 16'h0000);

  // Next-state logic
  always_comb begin
    logic [7:0] wb;
    logic       load_buf;
    logic       ninth;
    logic       rx_set;
    logic       tx_set;
    wb       = 8'h00;
    load_buf = 1'b0;
    ninth    = 1'b0;
    rx_set   = 1'b0;
    tx_set   = 1'b0;
    st_nxt   = st_r;
    st_nxt.ack     = acc;
    st_nxt.rx_prev = rx_lvl;
    st_nxt.ck_prev = ck_lvl;

    // Oversample divider enable pulse
    st_nxt.div_cnt = tick ? div_top : st_r.div_cnt - 16'h0001;

    // Async receiver
    if (!sync_mode && rx_on) begin
      if (st_r.baud_ctrl[serial_port_pkg::BC_WAKE]) begin
        // Falling edge wakes, nothing received
        if (st_r.rx_prev && !rx_lvl) begin
          rx_set = 1'b1;
          st_nxt.baud_ctrl[serial_port_pkg::BC_WAKE] = 1'b0;
        end
      end else if (tick) begin
        st_nxt.smp_cnt = st_r.smp_cnt + 4'h1;
        unique case (st_r.rx_st)
          RX_IDLE: begin
            if (!rx_lvl) begin
              st_nxt.rx_st   = RX_START;
              st_nxt.smp_cnt = 4'h0;
            end
          end
          RX_START: begin
            if (st_r.smp_cnt == serial_port_pkg::MID_SAMPLE) begin
              st_nxt.rx_st   = rx_lvl ? RX_IDLE : RX_DATA;
              st_nxt.smp_cnt = 4'h0;
              st_nxt.bit_cnt = 4'h0;
            end
          end
          RX_DATA: begin
            if (st_r.smp_cnt == serial_port_pkg::OVERSAMPLE) begin
              st_nxt.rx_shift = {rx_lvl, st_r.rx_shift[8:1]};
              st_nxt.bit_cnt  = st_r.bit_cnt + 4'h1;
              if (st_r.bit_cnt ==
                  (st_r.rcv_ctrl[serial_port_pkg::RC_NINE] ? 4'h8 : 4'h7))
              begin
                st_nxt.rx_st = RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (st_r.smp_cnt == serial_port_pkg::OVERSAMPLE) begin
              st_nxt.rx_st = RX_IDLE;
              load_buf = 1'b1;
              st_nxt.rcv_ctrl[serial_port_pkg::RC_FRAME_ERR] = ~rx_lvl;
            end
          end
        endcase
      end
    end else begin
      st_nxt.rx_st = RX_IDLE;
      // Bit count restarts while reception is off, no stale count
      if (!rx_on) begin
        st_nxt.bit_cnt = 4'h0;
      end
    end

    // Auto-baud timer runs while enabled in async mode
    if (!sync_mode && st_r.baud_ctrl[serial_port_pkg::BC_AB_EN]) begin
      st_nxt.ab_cnt = st_r.ab_cnt + 1'b1;
      if (&st_r.ab_cnt) begin
        st_nxt.baud_ctrl[serial_port_pkg::BC_AB_OVF] = 1'b1;
      end
    end else begin
      st_nxt.ab_cnt = '0;
      st_nxt.baud_ctrl[serial_port_pkg::BC_AB_OVF] = 1'b0;
    end

    // Idle flag low from start bit to character end
    st_nxt.baud_ctrl[serial_port_pkg::BC_IDLE] = (st_nxt.rx_st == RX_IDLE);

    // Sync slave: shift on master's clock only
    if (sync_mode && st_r.rcv_ctrl[serial_port_pkg::RC_PORT_EN]
        && !st_r.xmt_ctrl[serial_port_pkg::TX_CLK_MST]) begin
      if (rx_on && ck_fall) begin
        st_nxt.rx_shift = {rx_lvl, st_r.rx_shift[8:1]};
        st_nxt.bit_cnt  = st_r.bit_cnt + 4'h1;
        if (st_r.bit_cnt ==
            (st_r.rcv_ctrl[serial_port_pkg::RC_NINE] ? 4'h8 : 4'h7)) begin
          st_nxt.bit_cnt = 4'h0;
          load_buf = 1'b1;
        end
      end
      if (!rx_on && st_r.tx_busy && ck_rise) begin
        st_nxt.tx_shift = {1'b1, st_r.tx_shift[8:1]};
        st_nxt.tx_left  = st_r.tx_left - 4'h1;
        if (st_r.tx_left == 4'h1) begin
          st_nxt.tx_busy = 1'b0;
        end
      end
    end

    // Transmit register to shifter; one per shift-out in Sleep
    if (st_r.xmt_full && !st_nxt.tx_busy
        && st_r.xmt_ctrl[serial_port_pkg::TX_EN]) begin
      st_nxt.tx_shift = {st_r.xmt_ninth, st_r.xmt_reg};
      st_nxt.tx_left  = st_r.xmt_ctrl[serial_port_pkg::TX_NINE]
                      ? 4'h9 : 4'h8;
      st_nxt.tx_busy  = 1'b1;
      st_nxt.xmt_full = 1'b0;
      tx_set = 1'b1;
    end

    // Buffer load; address mode keeps ninth-bit-one only
    ninth = st_nxt.rcv_ctrl[serial_port_pkg::RC_NINE] ? st_nxt.rx_shift[8]
                                                      : 1'b0;
    if (load_buf) begin
      if (!(st_r.rcv_ctrl[serial_port_pkg::RC_ADDR_DET]
            && st_r.rcv_ctrl[serial_port_pkg::RC_NINE] && !ninth)) begin
        // Address detect cleared: all characters pass
        if (st_r.irq_stat[serial_port_pkg::IRQ_RX]) begin
          st_nxt.rcv_ctrl[serial_port_pkg::RC_OVERRUN] = 1'b1;
        end else begin
          st_nxt.rcv_buf = st_nxt.rcv_ctrl[serial_port_pkg::RC_NINE]
                         ? st_nxt.rx_shift[7:0] : st_nxt.rx_shift[8:1];
          // Ninth bit always one in address mode
          st_nxt.rcv_ctrl[serial_port_pkg::RC_NINTH] = ninth;
          rx_set = 1'b1;
        end
      end
    end

    // Register writes
    if (wr_hit) begin
      wb = lane0(8'h00, avs_writedata_in, avs_byteenable_in);
      if (avs_byteenable_in[0]) begin
        unique case (avs_address_in)
          serial_port_pkg::RCV_CTRL_ADDR: begin
            st_nxt.rcv_ctrl[7:3] = wb[7:3];
          end
          serial_port_pkg::XMT_CTRL_ADDR: begin
            st_nxt.xmt_ctrl[7:4] = wb[7:4];
            st_nxt.xmt_ctrl[serial_port_pkg::TX_NINTH] = wb[0];
          end
          serial_port_pkg::BAUD_CTRL_ADDR: begin
            st_nxt.baud_ctrl[serial_port_pkg::BC_WIDE]  = wb[3];
            st_nxt.baud_ctrl[serial_port_pkg::BC_WAKE]  = wb[1];
            st_nxt.baud_ctrl[serial_port_pkg::BC_AB_EN] = wb[0];
          end
          serial_port_pkg::BAUD_LO_ADDR: st_nxt.divisor[7:0]  = wb;
          serial_port_pkg::BAUD_HI_ADDR: st_nxt.divisor[15:8] = wb;
          serial_port_pkg::XMT_REG_ADDR: begin
            // Ninth bit latched with the low byte
            st_nxt.xmt_reg   = wb;
            st_nxt.xmt_ninth = st_r.xmt_ctrl[serial_port_pkg::TX_NINTH];
            st_nxt.xmt_full  = 1'b1;
          end
          serial_port_pkg::IRQ_STAT_ADDR: begin
            st_nxt.irq_stat = st_r.irq_stat & ~wb[1:0];
          end
          serial_port_pkg::IRQ_MASK_ADDR: st_nxt.irq_mask = wb[1:0];
          serial_port_pkg::SYS_CTRL_ADDR: st_nxt.sys_ctrl = wb[2:0];
          default: begin
          end
        endcase
      end
    end

    // Overrun clears while continuous receive is off
    if (!st_nxt.rcv_ctrl[serial_port_pkg::RC_CONT]) begin
      st_nxt.rcv_ctrl[serial_port_pkg::RC_OVERRUN] = 1'b0;
    end

    // Reading the buffer releases the receive flag
    if (avs_read_in && !st_r.ack && avs_address_in ==
        serial_port_pkg::RCV_BUF_ADDR) begin
      st_nxt.irq_stat[serial_port_pkg::IRQ_RX] = 1'b0;
    end

    // Events win over clears
    if (rx_set) begin
      st_nxt.irq_stat[serial_port_pkg::IRQ_RX] = 1'b1;
    end
    if (tx_set) begin
      st_nxt.irq_stat[serial_port_pkg::IRQ_TX] = 1'b1;
    end
    st_nxt.xmt_ctrl[serial_port_pkg::TX_EMPTY] = ~st_nxt.tx_busy;

    // Read data mux
    unique case (avs_address_in)
      serial_port_pkg::RCV_CTRL_ADDR:  st_nxt.rdata = {24'h0, st_r.rcv_ctrl};
      serial_port_pkg::XMT_CTRL_ADDR:  st_nxt.rdata = {24'h0, st_r.xmt_ctrl};
      serial_port_pkg::BAUD_CTRL_ADDR: st_nxt.rdata = {24'h0, st_r.baud_ctrl};
      serial_port_pkg::BAUD_LO_ADDR:
        st_nxt.rdata = {24'h0, st_r.divisor[7:0]};
      serial_port_pkg::BAUD_HI_ADDR:
        st_nxt.rdata = {24'h0, st_r.divisor[15:8]};
      serial_port_pkg::RCV_BUF_ADDR:   st_nxt.rdata = {24'h0, st_r.rcv_buf};
      serial_port_pkg::IRQ_STAT_ADDR:
        st_nxt.rdata = {30'h0, st_r.irq_stat};
      serial_port_pkg::IRQ_MASK_ADDR:
        st_nxt.rdata = {30'h0, st_r.irq_mask};
      serial_port_pkg::SYS_CTRL_ADDR:
        st_nxt.rdata = {29'h0, st_r.sys_ctrl};
      default: st_nxt.rdata = 32'h0000_0000;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
      st_r.xmt_ctrl  <= serial_port_pkg::XMT_CTRL_RST;
      st_r.baud_ctrl <= serial_port_pkg::BAUD_CTRL_RST;
      st_r.rcv_ctrl  <= serial_port_pkg::RCV_CTRL_RST;
      st_r.rx_prev   <= 1'b1;
      st_r.rx_st     <= RX_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~st_r.ack;
  assign avs_readdata_out    = st_r.rdata;
  assign dt_out              = st_r.tx_shift[0];
  assign dt_oe_out           = st_r.tx_busy & sync_mode & ~rx_on;
  // Flag gated by its enable
  assign irq_out  = |(st_r.irq_stat & st_r.irq_mask);
  // Wake from Sleep needs peripheral enable
  assign wake_out = st_r.sys_ctrl[serial_port_pkg::SC_SLEEP]
                  & st_r.sys_ctrl[serial_port_pkg::SC_PERI] & irq_out;

endmodule

/* dv/serial_port_checker.sv */
// Checker for bus handshake, interrupt and wake outputs.
// Assumes binding to serial_port; sees its ports only.
`timescale 1ns/10ps
module serial_port_checker #(
  parameter int AB_WIDTH = 16
) (
  // Clock and reset
  input wire logic        sys_clk_in,
  input wire logic        rst_n_in,
  // Register bus
  input wire logic [3:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  // Pins
  input wire logic        rx_pin_in,
  input wire logic        ck_pin_in,
  input wire logic        dt_out,
  input wire logic        dt_oe_out,
  input wire logic        irq_out,
  input wire logic        wake_out
);
  logic req;
  logic rd_ok;
  logic mask_clr;
  // Request, read answer and a mask write of zero
  assign req = avs_read_in | avs_write_in;
  assign rd_ok = avs_read_in & ~avs_waitrequest_out;
  assign mask_clr = avs_write_in & avs_waitrequest_out & avs_byteenable_in[0]
    & (avs_address_in == serial_port_pkg::IRQ_MASK_ADDR)
    & (avs_writedata_in[1:0] == 2'h0);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================
  // Properties
  property p_wait_rise; $rose(req) |-> avs_waitrequest_out; endproperty
  property p_wait_one; avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  property p_wait_idle; !req |-> !avs_waitrequest_out; endproperty
  property p_rd_upper; rd_ok |-> avs_readdata_out[31:8] == 24'h0;
  endproperty
  property p_rd_unmap;
    rd_ok && avs_address_in > 4'h9 |-> avs_readdata_out == 32'h0;
  endproperty
  property p_wake_irq; wake_out |-> irq_out; endproperty
  property p_irq_fell;
    $fell(irq_out) |-> $past(req) || $past(req, 2)
      || !$past(rst_n_in) || !$past(rst_n_in, 2);
  endproperty
  property p_mask_off; mask_clr |-> ##2 !irq_out; endproperty
  a_wait_rise: assert property (p_wait_rise) else $error("wait low");
  a_wait_one: assert property (p_wait_one) else $error("wait long");
  a_wait_idle: assert property (p_wait_idle) else $error("wait idle");
  a_rd_upper: assert property (p_rd_upper) else $error("upper bits");
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped");
  a_wake_irq: assert property (p_wake_irq) else $error("wake");
  a_irq_fell: assert property (p_irq_fell) else $error("irq fell");
  a_mask_off: assert property (p_mask_off) else $error("mask");
  // Main scenarios
  c_irq: cover property ($rose(irq_out));
  c_wake: cover property ($rose(wake_out));
  c_drive: cover property ($rose(dt_oe_out));
endmodule
bind serial_port serial_port_checker #(.AB_WIDTH(AB_WIDTH)) chk_i (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .rx_pin_in(rx_pin_in),
  .ck_pin_in(ck_pin_in), .dt_out(dt_out), .dt_oe_out(dt_oe_out),
  .irq_out(irq_out), .wake_out(wake_out));

/* dv/serial_far_end.sv */
// Far end: remote async transmitter and synchronous clock master.
// Assumes the bench calls its tasks just after a clock edge.
`timescale 1ns/10ps
module serial_far_end (
  // Pacing clock
  input wire logic clk_in,
  // Serial lines
  input wire logic dt_in,
  input wire logic dt_oe_in,
  output logic     rx_out,
  output logic     ck_out
);
  // Line idles high, clock stands low outside frames
  initial begin
    rx_out = 1'b1;
    ck_out = 1'b0;
  end
  // Async frame: start, data LSB first, stop
  task automatic send(input logic [8:0] d, input int nb, input int bc);
    logic b;
    for (int i = 0; i < nb + 2; i++) begin
      b = (i == 0) ? 1'b0 : (i > nb) ? 1'b1 : d[i-1];
      rx_out <= b;
      repeat (bc) @(posedge clk_in);
    end
  endtask
  // Short low pulse
  task automatic pulse(input int bc);
    rx_out <= 1'b0;
    repeat (bc) @(posedge clk_in);
    rx_out <= 1'b1;
  endtask
  // Eight clocks; slave data taken before each rise shifts it,
  // own data set at the rise for the slave's falling-edge sample
  task automatic clock_byte(input int h, input logic [7:0] d,
                            output logic [7:0] q);
    for (int i = 0; i < 8; i++) begin
      q[i] = dt_oe_in ? dt_in : 1'bx;
      rx_out <= d[i];
      ck_out <= 1'b1;
      repeat (h) @(posedge clk_in);
      ck_out <= 1'b0;
      repeat (h) @(posedge clk_in);
    end
    rx_out <= 1'b1;
  endtask
endmodule

/* dv/tb_serial_port.sv */
// Testbench for serial_port: register tests over Avalon-MM.
// Assumes serial_far_end drives the serial pins.
`timescale 1ns/10ps
module tb_serial_port;
  localparam logic [3:0] RC = serial_port_pkg::RCV_CTRL_ADDR;
  localparam logic [3:0] XC = serial_port_pkg::XMT_CTRL_ADDR;
  localparam logic [3:0] BC = serial_port_pkg::BAUD_CTRL_ADDR;
  localparam logic [3:0] BL = serial_port_pkg::BAUD_LO_ADDR;
  localparam logic [3:0] BUF = serial_port_pkg::RCV_BUF_ADDR;
  localparam logic [3:0] XR = serial_port_pkg::XMT_REG_ADDR;
  localparam logic [3:0] IS = serial_port_pkg::IRQ_STAT_ADDR;
  localparam logic [3:0] IM = serial_port_pkg::IRQ_MASK_ADDR;
  localparam logic [3:0] SC = serial_port_pkg::SYS_CTRL_ADDR;
  localparam int BIT = 32; // Sixteen ticks of two clocks
  logic        sys_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [3:0]  avs_address_in = 4'h0;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0]  avs_byteenable_in = 4'hf;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic        rx_pin_in;
  logic        ck_pin_in;
  logic        dt_out;
  logic        dt_oe_out;
  logic        irq_out;
  logic        wake_out;
  logic [7:0]  v;
  int          error_cnt = 0;
  int          n_tests = 0;
  // ==========================================================
  // Clock, design and far end
  always #20 sys_clk_in = ~sys_clk_in;
  serial_port #(.AB_WIDTH(8)) DUT (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .rx_pin_in(rx_pin_in),
    .ck_pin_in(ck_pin_in), .dt_out(dt_out), .dt_oe_out(dt_oe_out),
    .irq_out(irq_out), .wake_out(wake_out));
  serial_far_end far (.clk_in(sys_clk_in), .dt_in(dt_out),
    .dt_oe_in(dt_oe_out), .rx_out(rx_pin_in), .ck_out(ck_pin_in));
  // ==========================================================
  // Tasks
  task automatic close_out;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= {24'h0, d};
    avs_write_in <= 1'b1;
    @(posedge sys_clk_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge sys_clk_in);
    avs_write_in <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] m, e,
                     input string nm);
    @(posedge sys_clk_in);
    avs_address_in <= a;
    avs_read_in <= 1'b1;
    @(posedge sys_clk_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge sys_clk_in);
    chk(nm, e, avs_readdata_out[7:0] & m);
    avs_read_in <= 1'b0;
  endtask
  task automatic wirq(input logic e);
    int k;
    k = 0;
    while (irq_out !== e && k < 2000) begin
      @(posedge sys_clk_in);
      k++;
    end
    chk("irq", {7'h0, e}, {7'h0, irq_out});
  endtask
  // ==========================================================
  // Tests
  initial begin
    repeat (12) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    rdc(RC, 8'hff, 8'h00, "rc_rst");
    rdc(XC, 8'hff, 8'h02, "xc_rst");
    rdc(BC, 8'hff, 8'h40, "bc_rst");
    wr(4'hc, 8'hff);
    rdc(4'hc, 8'hff, 8'h00, "unmapped");
    wr(BC, 8'h08);
    rdc(BC, 8'hff, 8'h48, "wide");
    wr(BC, 8'h00);
    wr(BL, 8'h01);
    wr(IM, 8'h01);
    wr(RC, 8'h90);
    fork
      far.send(9'h0a5, 8, BIT);
      begin
        repeat (100) @(posedge sys_clk_in);
        rdc(BC, 8'h40, 8'h00, "busy");
      end
    join
    wirq(1'b1);
    rdc(IS, 8'h03, 8'h01, "rx_stat");
    rdc(RC, 8'hff, 8'h90, "rc_stat");
    rdc(BUF, 8'hff, 8'ha5, "rx_data");
    wirq(1'b0);
    rdc(BC, 8'h40, 8'h40, "idle");
    $display("test rx done");
    far.send(9'h03c, 8, BIT);
    far.send(9'h0c3, 8, BIT);
    rdc(RC, 8'hff, 8'h92, "overrun");
    wr(RC, 8'h80);
    rdc(RC, 8'hff, 8'h80, "ovr_clr");
    rdc(BUF, 8'hff, 8'h3c, "kept");
    $display("test overrun done");
    wr(RC, 8'hd8);
    far.send(9'h055, 9, BIT);
    repeat (40) @(posedge sys_clk_in);
    rdc(IS, 8'h01, 8'h00, "skip");
    far.send(9'h1a7, 9, BIT);
    wirq(1'b1);
    rdc(RC, 8'hff, 8'hd9, "ninth");
    rdc(BUF, 8'hff, 8'ha7, "addr");
    wr(RC, 8'hd0);
    far.send(9'h012, 9, BIT);
    wirq(1'b1);
    rdc(BUF, 8'hff, 8'h12, "all");
    $display("test address done");
    wr(RC, 8'h90);
    wr(BC, 8'h02);
    far.pulse(6);
    wirq(1'b1);
    rdc(BC, 8'h02, 8'h00, "wake_clr");
    wr(IS, 8'h01);
    rdc(IS, 8'h01, 8'h00, "w1c");
    wr(BC, 8'h01);
    repeat (300) @(posedge sys_clk_in);
    rdc(BC, 8'h80, 8'h80, "ab_ovf");
    wr(BC, 8'h00);
    rdc(BC, 8'h80, 8'h00, "ab_clr");
    $display("test wake done");
    wr(RC, 8'h80);
    wr(XC, 8'h30);
    wr(IM, 8'h02);
    wr(SC, 8'h03);
    wr(XR, 8'h5a);
    wr(XR, 8'h3c);
    wr(IS, 8'h02);
    rdc(IS, 8'h02, 8'h00, "tx_wait");
    chk("wake_wait", 8'h00, {7'h0, wake_out});
    far.clock_byte(8, 8'hff, v);
    chk("tx_byte", 8'h5a, v);
    wirq(1'b1);
    chk("wake", 8'h01, {7'h0, wake_out});
    wr(IM, 8'h00);
    wr(IS, 8'h03);
    wr(RC, 8'h90);
    far.clock_byte(8, 8'hc6, v);
    rdc(IS, 8'h01, 8'h01, "sync_flag");
    rdc(BUF, 8'hff, 8'hc6, "sync_rx");
    $display("test sync done");
    close_out;
  end
  // Watchdog
  initial begin
    repeat (40000) @(posedge sys_clk_in);
    error_cnt++;
    close_out;
  end
endmodule
